/* File: core/gdt_regs.sv */
// gdt driver timing and supply fault register bank, ahb-lite slave
//
// Function
// - dead time code sits in timing bits 4:2, 2000 ns at 0, 250 ns less per step.
// - blanking code sits in timing bits 1:0, 4000/2000/1000/500 ns.
// - timing bits 7:5 are not implemented and read zero.
// - status bit 7 is high while the buck output is below 80 percent.
// - status bit 6 is high while the buck output is below 90 percent.
// - status bit 5 is high while the buck input current is above 2 A peak.
// - status bit 4 is high while the supply input is above 32 V.
// - status bit 3 shows driver supply above 20 V, zero without the monitor.
// - status bit 2 is high while the supply input is below 5.5 V.
// - status bit 1 is high while the junction is at 160 C or more.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`include "gdt_defines.svh"
module gdt_regs #(
    parameter bit HAS_DRV_OVMON = 1'b1
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // monitor comparator levels
    input  wire logic                  buckUndervoltFaultIn,
    input  wire logic                  buckUndervoltWarningIn,
    input  wire logic                  buckInputOvercurrentWarningIn,
    input  wire logic                  inputOvervoltFaultIn,
    input  wire logic                  driverSupplyOvervoltFaultIn,
    input  wire logic                  inputUndervoltFaultIn,
    input  wire logic                  overtempFaultIn,
    input  wire logic                  overtempWarningIn,
    // gate drive timing
    output logic [2:0]                 deadTimeSelect,
    output logic [1:0]                 blankingTimeSelect,
    output logic [`GDT_CYC_W-1:0]      deadTimeCycles,
    output logic [`GDT_CYC_W-1:0]      blankingTimeCycles,
    // interrupt
    output logic                       irq
);
    import gdt_pkg::*;

    localparam gdt_regs_st_t ST_RST = '{readyOut: 1'b1, default: '0};

    gdt_regs_st_t st_r;
    gdt_regs_st_t st_nxt;
    logic         addrPhase;
    gdt_stat_t    monVec;
    logic [7:0]   irqEvt;
    logic [7:0]   irqClr;
    logic         irqMaskWe;
    logic [7:0]   irqStat;
    logic [7:0]   irqMask;
    logic         unusedBits;

    // word transfers only; size and upper address bits are not decoded
    assign unusedBits = ^{hsize, haddr[31:8], haddr[1:0]};

    always_comb begin
        st_nxt = st_r;
        addrPhase = hsel && htrans[1] && hready;
        // status mirrors the comparators one cycle late
        monVec = {buckUndervoltFaultIn,
                  buckUndervoltWarningIn,
                  buckInputOvercurrentWarningIn,
                  inputOvervoltFaultIn,
                  HAS_DRV_OVMON
                      && driverSupplyOvervoltFaultIn,
                  inputUndervoltFaultIn,
                  overtempFaultIn,
                  overtempWarningIn};
        st_nxt.stat = monVec;
        irqEvt = monVec & ~st_r.stat;
        irqClr = '0;
        irqMaskWe = 1'b0;
        // write data phase: data lands at its end
        if (st_r.wrPend) begin
            case (st_r.wrAddr)
                `GDT_OFS_TIMING: begin
                    // upper bits have no storage
                    st_nxt.cfg = gdt_cfg_t'(
                        hwdata[`GDT_TIMING_W-1:0]);
                end
                `GDT_OFS_IRQ_STAT: begin
                    irqClr = hwdata[7:0];
                end
                `GDT_OFS_IRQ_MASK: begin
                    irqMaskWe = 1'b1;
                end
                // status and unmapped writes are dropped
                default: begin
                    irqClr = '0;
                end
            endcase
        end
        st_nxt.wrPend = addrPhase && hwrite;
        if (addrPhase) begin
            st_nxt.wrAddr = haddr[7:0];
        end
        // timing and status read data built from next state so a timing write just before is seen
        st_nxt.rdata = '0;
        if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                `GDT_OFS_TIMING: begin
                    st_nxt.rdata = {27'h0000000, st_nxt.cfg};
                end
                `GDT_OFS_STATUS: begin
                    st_nxt.rdata = {24'h000000, st_nxt.stat};
                end
                `GDT_OFS_IRQ_STAT: begin
                    st_nxt.rdata = {24'h000000, irqStat};
                end
                `GDT_OFS_IRQ_MASK: begin
                    st_nxt.rdata = {24'h000000, irqMask};
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
        // zero wait state, always okay
        st_nxt.readyOut = 1'b1;
        st_nxt.respErr = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout = st_r.readyOut;
    assign hresp = st_r.respErr;
    assign hrdata = st_r.rdata;
    assign deadTimeSelect = st_r.cfg.deadSel;
    assign blankingTimeSelect = st_r.cfg.blankSel;

    gdt_time_decode u_decode (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .deadTimeSel  (st_r.cfg.deadSel),
        .blankTimeSel (st_r.cfg.blankSel),
        .deadCycles   (deadTimeCycles),
        .blankCycles  (blankingTimeCycles)
    );

    gdt_irq_ctrl u_irq (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .events    (irqEvt),
        .clearBits (irqClr),
        .maskWe    (irqMaskWe),
        .maskData  (hwdata[7:0]),
        .irqStat   (irqStat),
        .irqMask   (irqMask),
        .irq       (irq)
    );

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence sWrTiming;
        hsel && htrans[1] && hready && hwrite
            && haddr[7:0] == `GDT_OFS_TIMING ##1 hready;
    endsequence
    sequence sRdTiming;
        hsel && htrans[1] && hready && !hwrite
            && haddr[7:0] == `GDT_OFS_TIMING;
    endsequence
    sequence sWrStatus;
        hsel && htrans[1] && hready && hwrite
            && haddr[7:0] == `GDT_OFS_STATUS ##1 hready;
    endsequence
    sequence sRdStatus;
        hsel && htrans[1] && hready && !hwrite
            && haddr[7:0] == `GDT_OFS_STATUS;
    endsequence

    AST_DEAD_SEL:
    assert property (sWrTiming |=>
        deadTimeSelect == $past(hwdata[`GDT_DT_MSB:`GDT_DT_LSB]))
        else $error("dead time code not taken from write");

    AST_DEAD_CYC:
    assert property ($changed(deadTimeSelect) |=>
        int'(deadTimeCycles) == (`GDT_DT_MAX_NS - `GDT_DT_STEP_NS
            * int'($past(deadTimeSelect))) / `GDT_CLK_NS)
        else $error("dead time count wrong for code");

    AST_BLANK_SEL:
    assert property (sWrTiming |=>
        blankingTimeSelect == $past(hwdata[`GDT_BL_MSB:`GDT_BL_LSB]))
        else $error("blanking code not taken from write");

    AST_BLANK_CYC:
    assert property (##1 blankingTimeSelect == 2'h0 |=>
        int'(blankingTimeCycles) == `GDT_BL0_NS / `GDT_CLK_NS)
        else $error("blanking count wrong for code zero");

    AST_BLANK_FAST:
    assert property (##1 blankingTimeSelect == 2'h3 |=>
        int'(blankingTimeCycles) == `GDT_BL3_NS / `GDT_CLK_NS)
        else $error("blanking count wrong for code three");

    AST_TIMING_UPPER:
    assert property (sRdTiming |=> hrdata[31:`GDT_TIMING_W] == '0
        && hrdata[`GDT_TIMING_W-1:0] == {deadTimeSelect,
            blankingTimeSelect})
        else $error("timing read shows unimplemented bits");

    AST_BUCK_UV_FAULT:
    assert property (sRdStatus ##0 buckUndervoltFaultIn |=> hrdata[7])
        else $error("buck undervoltage fault not reported");

    AST_BUCK_UV_WARN:
    assert property (##1 st_r.stat.buckUvWarn
        == $past(buckUndervoltWarningIn))
        else $error("buck undervoltage warning does not follow");

    AST_BUCK_OC_WARN:
    assert property ($fell(buckInputOvercurrentWarningIn)
        |=> !st_r.stat.buckInOcWarn)
        else $error("buck overcurrent warning not cleared");

    AST_IN_OV_FAULT:
    assert property ($rose(inputOvervoltFaultIn) |=>
        st_r.stat.inOvFault ##1 st_r.stat.inOvFault
            == $past(inputOvervoltFaultIn))
        else $error("input overvoltage fault does not follow");

    AST_DRV_OV_FAULT:
    assert property (##1 st_r.stat.drvOvFault
        == (HAS_DRV_OVMON && $past(driverSupplyOvervoltFaultIn)))
        else $error("driver supply overvoltage flag wrong");

    AST_IN_UV_FAULT:
    assert property (sRdStatus ##0 !inputUndervoltFaultIn |=> !hrdata[2])
        else $error("input undervoltage fault stuck");

    AST_OT_FAULT:
    assert property (overtempFaultIn [*2] |=> st_r.stat.otFault [*1])
        else $error("overtemperature fault not reported");

    AST_OT_WARN:
    assert property (##1 st_r.stat.otWarn == $past(overtempWarningIn))
        else $error("overtemperature warning does not follow");

    AST_STATUS_RO:
    assert property (sWrStatus |=> st_r.stat == $past(monVec))
        else $error("status register changed by a write");

    AST_IRQ_LEVEL:
    assert property (##1 irq == |(irqStat & irqMask))
        else $error("interrupt level disagrees with status and mask");

    AST_IRQ_SET_WINS:
    assert property (irqEvt != '0 |=> (irqStat & $past(irqEvt))
        == $past(irqEvt))
        else $error("interrupt event lost");

    AST_BUS_OKAY:
    assert property (hreadyout && !hresp)
        else $error("slave stalled or answered error");

endmodule

/* File: pkg/gdt_defines.svh */
// gdt register bank constants: offsets, fields, resets and timings
`ifndef GDT_DEFINES_SVH
`define GDT_DEFINES_SVH
// system clock
`define GDT_CLK_NS 10
// register byte offsets on the ahb-lite bus
`define GDT_OFS_TIMING 8'h00
`define GDT_OFS_STATUS 8'h04
`define GDT_OFS_IRQ_STAT 8'h08
`define GDT_OFS_IRQ_MASK 8'h0c
// reset values
`define GDT_TIMING_RST 5'h00
`define GDT_STATUS_RST 8'h00
`define GDT_IRQ_MASK_RST 8'h00
// driver timing field positions
`define GDT_DT_MSB 4
`define GDT_DT_LSB 2
`define GDT_BL_MSB 1
`define GDT_BL_LSB 0
`define GDT_TIMING_W 5
// dead time: code 0 is the longest, each step shortens it
`define GDT_DT_MAX_NS 2000
`define GDT_DT_STEP_NS 250
// blanking times per code
`define GDT_BL0_NS 4000
`define GDT_BL1_NS 2000
`define GDT_BL2_NS 1000
`define GDT_BL3_NS 500
// width of a cycle count
`define GDT_CYC_W 10
`endif

/* File: pkg/gdt_pkg.sv */
// gdt register bank types
package gdt_pkg;
    typedef struct packed {
        logic [2:0] deadSel;
        logic [1:0] blankSel;
    } gdt_cfg_t;
    typedef struct packed {
        logic buckUvFault;
        logic buckUvWarn;
        logic buckInOcWarn;
        logic inOvFault;
        logic drvOvFault;
        logic inUvFault;
        logic otFault;
        logic otWarn;
    } gdt_stat_t;
    typedef struct packed {
        logic       readyOut;
        logic       respErr;
        logic       wrPend;
        logic [7:0] wrAddr;
        gdt_cfg_t   cfg;
        gdt_stat_t  stat;
        logic [31:0] rdata;
    } gdt_regs_st_t;
    typedef struct packed {
        logic [9:0] deadCyc;
        logic [9:0] blankCyc;
    } gdt_dec_st_t;
    typedef struct packed {
        logic [7:0] stat;
        logic [7:0] mask;
        logic       irq;
    } gdt_irq_st_t;
endpackage

/* File: core/gdt_time_decode.sv */
// gdt timing decoder: selection codes to system clock cycle counts
`include "gdt_defines.svh"
module gdt_time_decode (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // selection codes
    input  wire logic [2:0]            deadTimeSel,
    input  wire logic [1:0]            blankTimeSel,
    // cycle counts
    output logic [`GDT_CYC_W-1:0]      deadCycles,
    output logic [`GDT_CYC_W-1:0]      blankCycles
);
    import gdt_pkg::*;
    gdt_dec_st_t st_r;
    gdt_dec_st_t st_nxt;
    // least times, so round up
    function automatic logic [`GDT_CYC_W-1:0] nsToCyc(input int ns);
        nsToCyc = `GDT_CYC_W'((ns + `GDT_CLK_NS - 1) / `GDT_CLK_NS);
    endfunction
    always_comb begin
        st_nxt = st_r;
        st_nxt.deadCyc = nsToCyc(`GDT_DT_MAX_NS
            - `GDT_DT_STEP_NS * int'(deadTimeSel));
        unique case (blankTimeSel)
            2'h0: st_nxt.blankCyc = nsToCyc(`GDT_BL0_NS);
            2'h1: st_nxt.blankCyc = nsToCyc(`GDT_BL1_NS);
            2'h2: st_nxt.blankCyc = nsToCyc(`GDT_BL2_NS);
            2'h3: st_nxt.blankCyc = nsToCyc(`GDT_BL3_NS);
        endcase
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign deadCycles = st_r.deadCyc;
    assign blankCycles = st_r.blankCyc;
endmodule

/* File: core/gdt_irq_ctrl.sv */
// gdt interrupt status, mask and level output
module gdt_irq_ctrl (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // events and software access
    input  wire logic [7:0] events,
    input  wire logic [7:0] clearBits,
    input  wire logic       maskWe,
    input  wire logic [7:0] maskData,
    // state
    output logic [7:0]      irqStat,
    output logic [7:0]      irqMask,
    output logic            irq
);
    import gdt_pkg::*;
    gdt_irq_st_t st_r;
    gdt_irq_st_t st_nxt;
    always_comb begin
        st_nxt = st_r;
        // a new event beats a clear in the same cycle
        st_nxt.stat = (st_r.stat & ~clearBits) | events;
        if (maskWe) begin
            st_nxt.mask = maskData;
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign irqStat = st_r.stat;
    assign irqMask = st_r.mask;
    assign irq = st_r.irq;
endmodule

/* File: testbench/gdt_regs_bench.sv */
// self-checking bench for the gdt timing and fault status register bank
`include "gdt_defines.svh"
module gdt_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] ATIMING  = {24'h0, `GDT_OFS_TIMING};
    localparam logic [31:0] ASTATUS  = {24'h0, `GDT_OFS_STATUS};
    localparam logic [31:0] AIRQSTAT = {24'h0, `GDT_OFS_IRQ_STAT};
    localparam logic [31:0] AIRQMASK = {24'h0, `GDT_OFS_IRQ_MASK};
    logic        clock;
    logic        sysRst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] varRdata;
    logic [7:0]  monIn;
    logic [2:0]  deadSel;
    logic [1:0]  blankSel;
    logic [9:0]  deadCyc;
    logic [9:0]  blankCyc;
    logic        irq;
    logic        useVar;
    logic [4:0]  code;
    logic [7:0]  expVar;
    int          errors;
    int          totalChecks;

    gdt_regs #(.HAS_DRV_OVMON(1'b1)) i_dut (
        .clock(clock), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .buckUndervoltFaultIn(monIn[7]),
        .buckUndervoltWarningIn(monIn[6]),
        .buckInputOvercurrentWarningIn(monIn[5]),
        .inputOvervoltFaultIn(monIn[4]),
        .driverSupplyOvervoltFaultIn(monIn[3]),
        .inputUndervoltFaultIn(monIn[2]), .overtempFaultIn(monIn[1]),
        .overtempWarningIn(monIn[0]), .deadTimeSelect(deadSel),
        .blankingTimeSelect(blankSel), .deadTimeCycles(deadCyc),
        .blankingTimeCycles(blankCyc), .irq(irq));

    // variant without the driver supply monitor shares the bus
    gdt_regs #(.HAS_DRV_OVMON(1'b0)) i_dut_var (
        .clock(clock), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(varRdata),
        .buckUndervoltFaultIn(monIn[7]), .buckUndervoltWarningIn(monIn[6]),
        .buckInputOvercurrentWarningIn(monIn[5]),
        .inputOvervoltFaultIn(monIn[4]),
        .driverSupplyOvervoltFaultIn(monIn[3]),
        .inputUndervoltFaultIn(monIn[2]), .overtempFaultIn(monIn[1]),
        .overtempWarningIn(monIn[0]), .deadTimeSelect(),
        .blankingTimeSelect(), .deadTimeCycles(), .blankingTimeCycles(),
        .irq());

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic test_done;
        if (errors == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got,
                       input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // sampled at the falling edge so the value is settled across the edge
    task automatic wait_ready(output logic [31:0] rd);
        logic rdy;
        int   n;
        n = 0;
        do begin
            @(negedge clock);
            rdy = hreadyout;
            totalChecks++;
            if (hresp !== 1'b0) begin
                errors++;
                $display("BAD hresp expected 0 seen %b", hresp);
            end
            rd = useVar ? varRdata : hrdata;
            @(posedge clock);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) begin
            errors++;
            $display("BAD hreadyout expected 1 seen %b", rdy);
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] addr,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic [31:0] unused;
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= addr;
        hwrite <= wr;
        wait_ready(unused);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready(rd);
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, addr, wd, rd);
    endtask

    task automatic rd_chk(input string name, input logic [31:0] addr,
                          input logic [31:0] exp);
        logic [31:0] rd;
        xfer(1'b0, addr, 32'h0, rd);
        chk(name, rd, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done();
    end

    initial begin
        sysRst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        monIn = 8'h00;
        useVar = 1'b0;
        errors = 0;
        totalChecks = 0;
        repeat (16) @(posedge clock);
        sysRst <= 1'b0;
        idle(2);
        chk("deadCyc", {22'h0, deadCyc}, 32'd200);
        chk("blankCyc", {22'h0, blankCyc}, 32'd400);
        chk("irq", {31'h0, irq}, 32'h0);
        rd_chk("timing", ATIMING, 32'h0);
        rd_chk("status", ASTATUS, 32'h0);
        rd_chk("irqMask", AIRQMASK, 32'h0);
        rd_chk("unmapped", 32'h10, 32'h0);
        // every code pair, with the unimplemented bits written high
        for (int c = 0; c < 32; c++) begin
            code = c[4:0];
            wr(ATIMING, {27'h7ffffff, code});
            idle(1);
            chk("deadSel", {29'h0, deadSel}, {29'h0, code[4:2]});
            chk("blankSel", {30'h0, blankSel}, {30'h0, code[1:0]});
            chk("deadCyc", {22'h0, deadCyc},
                32'(200 - 25 * int'(code[4:2])));
            chk("blankCyc", {22'h0, blankCyc},
                32'(400 >> code[1:0]));
            rd_chk("timing", ATIMING, {27'h0, code});
        end
        wr(32'h10, 32'h0);
        rd_chk("timing", ATIMING, 32'h1f);
        // one monitor at a time, on both variants
        for (int b = 0; b < 8; b++) begin
            monIn <= 8'h01 << b;
            expVar = (b == 3) ? 8'h00 : 8'h01 << b;
            idle(2);
            // below
            rd_chk("status", ASTATUS, 32'h1 << b);
            useVar = 1'b1;
            rd_chk("statusVar", ASTATUS, {24'h0, expVar});
            useVar = 1'b0;
        end
        monIn <= 8'hff;
        idle(2);
        wr(ASTATUS, 32'h0);
        rd_chk("status", ASTATUS, 32'hff);
        useVar = 1'b1;
        rd_chk("statusVar", ASTATUS, 32'hf7);
        useVar = 1'b0;
        monIn <= 8'h00;
        idle(2);
        wr(ASTATUS, 32'hff);
        rd_chk("status", ASTATUS, 32'h0);
        // sticky events, mask and write-one-to-clear
        rd_chk("irqStat", AIRQSTAT, 32'hff);
        idle(1);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(AIRQMASK, 32'h01);
        idle(1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(AIRQSTAT, 32'hff);
        idle(1);
        chk("irq", {31'h0, irq}, 32'h0);
        rd_chk("irqStat", AIRQSTAT, 32'h0);
        rd_chk("irqMask", AIRQMASK, 32'h01);
        wr(AIRQMASK, 32'h02);
        monIn <= 8'h02;
        idle(3);
        chk("irq", {31'h0, irq}, 32'h1);
        rd_chk("irqStat", AIRQSTAT, 32'h02);
        wr(AIRQMASK, 32'h00);
        idle(1);
        chk("irq", {31'h0, irq}, 32'h0);
        test_done();
    end
endmodule
